// ==== logic/srr_pkg.sv ====
package srr_pkg;

  // ----------------------------------------------------------------
  // Protocol, slot and state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PROTO_I2C = 2'h0,
    PROTO_SPI = 2'h1,
    PROTO_MW  = 2'h2
  } srr_proto_type;

  typedef enum logic [2:0] {
    K_START = 3'h0,
    K_STOP  = 3'h1,
    K_BITS  = 3'h2,
    K_WAIT  = 3'h3,
    K_SEL   = 3'h4,
    K_DESEL = 3'h5
  } srr_slot_type;

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_DESEL   = 3'h1,
    S_POLL    = 3'h3,
    S_CHECK   = 3'h2,
    S_DISABLE = 3'h6,
    S_DONE    = 3'h7,
    S_FAIL    = 3'h5
  } srr_state_type;

  typedef struct packed {
    srr_slot_type kind;
    logic [4:0]   nbits;
    logic [15:0]  tx;
  } srr_slot_req_type;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int QUARTER_NS    = 1250;
  localparam int QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Sequence figures and command codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  RESYNC_STARTS           = 4'h9;
  localparam logic [4:0]  I2C_POLL_BITS           = 5'h09;
  localparam logic [4:0]  SPI_POLL_BITS           = 5'h10;
  localparam logic [4:0]  SPI_CMD_BITS            = 5'h08;
  localparam logic [4:0]  MW_HEAD_BITS            = 5'h05;
  localparam logic [7:0]  SPI_READ_STATUS_CMD     = 8'h05;
  localparam logic [7:0]  WRITE_DISABLE_CMD       = 8'h04;
  localparam logic [15:0] ERASE_WRITE_DISABLE_CMD = 16'h9800;
  localparam int          WRITE_IN_PROGRESS_BIT   = 0;
  localparam int          WRITE_ENABLE_LATCH_FLAG = 1;

  // ----------------------------------------------------------------
  // Reset values of the pins
  // ----------------------------------------------------------------
  localparam logic RST_SPI_CS_N = 1'b1;
  localparam logic RST_MW_CS    = 1'b0;
  localparam logic RST_WP_N     = 1'b1;

endpackage

// ==== logic/srr_sync2.sv ====
`timescale 1ns/100ps
module srr_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule // srr_sync2

// ==== logic/srr_recovery_host.sv ====
`timescale 1ns/100ps
// Summary of operation
// - After restart, poll for write completion before any new access.
// - On I2C, master reset must not produce a Stop condition.
// - On I2C send nine Starts then one Stop before accessing again.
// - After I2C resync, poll until no write in progress.
// - Current-address read keeps the pointer; first read should be random.
// - Small SPI parts drop the pending write if protect is low before deselect.
// - Deselect respecting chip select to clock rising edge timing.
// - After SPI restart, poll status until no write in progress.
// - When SPI is ready and latch flag reads 1, send write disable.
// - After MICROWIRE restart, poll until the memory is ready.
// - When MICROWIRE is ready, send erase/write disable.
// - The recovery sequence runs every time the master leaves reset.
module srr_recovery_host
  import srr_pkg::*;
#(
  parameter int         POLL_MAX     = 64,
  parameter int         MW_ADDR_BITS = 6,
  parameter logic [7:0] I2C_DEV_SEL  = 8'hA0
) (
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_start,
  input  wire srr_proto_type i_protocol,
  input  wire logic          i_pointer_loaded,
  input  wire logic          i_sda,
  input  wire logic          i_serial_in,
  output logic               o_scl,
  output logic               o_scl_oe_n,
  output logic               o_sda,
  output logic               o_sda_oe_n,
  output logic               o_spi_cs_n,
  output logic               o_mw_cs,
  output logic               o_sck,
  output logic               o_mosi,
  output logic               o_wp_n,
  output logic               o_busy,
  output logic               o_ready,
  output logic               o_failed,
  output logic               o_need_random_read
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int             QW     = $clog2(QUARTER_CYC + 1);
  localparam logic [QW-1:0]  Q_LAST = QW'(QUARTER_CYC - 1);
  localparam int             PW     = $clog2(POLL_MAX + 1);
  localparam logic [PW-1:0]  P_LAST = PW'(POLL_MAX - 1);
  localparam logic [4:0]     MW_DIS_BITS = MW_HEAD_BITS + 5'(MW_ADDR_BITS - 2);

  srr_state_type    state;
  srr_proto_type    proto;
  srr_slot_type     slot_kind;
  srr_slot_req_type req;
  logic [3:0]       step;
  logic [3:0]       last_step;
  logic [PW-1:0]    poll_cnt;
  logic             boot;
  logic             waiting;
  logic             go;
  logic             slot_busy;
  logic             slot_done;
  logic [QW-1:0]    div_cnt;
  logic [1:0]       quarter;
  logic [4:0]       bit_cnt;
  logic [15:0]      tx_sh;
  logic [15:0]      rx_sh;
  logic             tick;
  logic             last_q;
  logic             more_bits;
  logic             act_en;
  logic [1:0]       act_q;
  srr_slot_type     act_kind;
  logic             act_bit;
  logic [1:0]       din_sync;
  logic             din;
  logic             poll_ready;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  srr_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      ({i_sda, i_serial_in}),
    .o_q      (din_sync)
  );

  assign din = (proto == PROTO_I2C) ? din_sync[1] : din_sync[0];

  // ----------------------------------------------------------------
  // Slot program per state and step
  // ----------------------------------------------------------------
  always_comb begin
    req       = '{kind: K_WAIT, nbits: 5'h01, tx: 16'h0000};
    last_step = 4'h0;
    unique case (state)
      S_DESEL: begin
        if (proto == PROTO_I2C) begin
          last_step = RESYNC_STARTS;
          req.kind  = (step == RESYNC_STARTS) ? K_STOP : K_START;
        end else begin
          req.kind = K_DESEL;
        end
      end
      S_POLL: begin
        last_step = 4'h2;
        if (proto == PROTO_I2C) begin
          req.kind  = (step == 4'h0) ? K_START : (step == 4'h1) ? K_BITS : K_STOP;
          req.nbits = I2C_POLL_BITS;
          req.tx    = {I2C_DEV_SEL, 1'b1, 7'h00};
        end else begin
          req.kind  = (step == 4'h0) ? K_SEL : (step == 4'h2) ? K_DESEL :
                      (proto == PROTO_MW) ? K_WAIT : K_BITS;
          req.nbits = (proto == PROTO_MW) ? 5'h01 : SPI_POLL_BITS;
          req.tx    = {SPI_READ_STATUS_CMD, 8'h00};
        end
      end
      S_DISABLE: begin
        last_step = 4'h2;
        req.kind  = (step == 4'h0) ? K_SEL : (step == 4'h1) ? K_BITS : K_DESEL;
        if (proto == PROTO_MW) begin
          req.nbits = MW_DIS_BITS;
          req.tx    = ERASE_WRITE_DISABLE_CMD;
        end else begin
          req.nbits = SPI_CMD_BITS;
          req.tx    = {WRITE_DISABLE_CMD, 8'h00};
        end
      end
      default: ;
    endcase
  end

  assign go = ((state == S_DESEL) || (state == S_POLL) || (state == S_DISABLE)) && !waiting;

  // ----------------------------------------------------------------
  // Slot engine: each bit or condition takes four quarter periods
  // ----------------------------------------------------------------
  assign tick      = slot_busy && (div_cnt == Q_LAST);
  assign last_q    = (quarter == 2'h3);
  assign more_bits = (slot_kind == K_BITS) && (bit_cnt != 5'h01);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slot_busy <= 1'b0;
      slot_kind <= K_WAIT;
      bit_cnt   <= 5'h00;
      tx_sh     <= 16'h0000;
      quarter   <= 2'h0;
      div_cnt   <= '0;
    end else if (go) begin
      slot_busy <= 1'b1;
      slot_kind <= req.kind;
      bit_cnt   <= req.nbits;
      tx_sh     <= req.tx;
      quarter   <= 2'h0;
      div_cnt   <= '0;
    end else if (tick) begin
      div_cnt <= '0;
      quarter <= quarter + 2'h1;
      if (last_q) begin
        if (more_bits) begin
          bit_cnt <= bit_cnt - 5'h01;
          tx_sh   <= {tx_sh[14:0], 1'b0};
        end else begin
          slot_busy <= 1'b0;
        end
      end
    end else if (slot_busy) begin
      div_cnt <= div_cnt + QW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slot_done <= 1'b0;
    end else begin
      slot_done <= tick && last_q && !more_bits;
    end
  end

  // Sampling late in the high clock phase leaves the line two full quarters after the rising clock edge to settle.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_sh <= 16'h0000;
    end else if (tick && (quarter == 2'h2) && ((slot_kind == K_BITS) || (slot_kind == K_WAIT))) begin
      rx_sh <= {rx_sh[14:0], din};
    end
  end

  // ----------------------------------------------------------------
  // Pin actions at the start of each quarter
  // ----------------------------------------------------------------
  assign act_en   = go || (tick && (!last_q || more_bits));
  assign act_q    = (go || last_q) ? 2'h0 : quarter + 2'h1;
  assign act_kind = go ? req.kind : slot_kind;
  assign act_bit  = go ? req.tx[15] : (last_q ? tx_sh[14] : tx_sh[15]);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // Released lines hold their level through master reset, so no Stop is made here.
      o_scl_oe_n <= 1'b1;
      o_sda_oe_n <= 1'b1;
      o_scl      <= 1'b0;
      o_sda      <= 1'b0;
      o_spi_cs_n <= RST_SPI_CS_N;
      o_mw_cs    <= RST_MW_CS;
      o_sck      <= 1'b0;
      o_mosi     <= 1'b0;
      o_wp_n     <= RST_WP_N;
    end else if (act_en) begin
      if (proto == PROTO_I2C) begin
        unique case (act_kind)
          K_START: begin
            // Data falls while the clock is high; this restarts the memory unless the memory is holding data low.
            if (act_q == 2'h0) o_sda_oe_n <= 1'b1;
            if (act_q == 2'h1) o_scl_oe_n <= 1'b1;
            if (act_q == 2'h2) o_sda_oe_n <= 1'b0;
            if (act_q == 2'h3) o_scl_oe_n <= 1'b0;
          end
          K_STOP: begin
            // Stops follow a Start or a poll byte only, never a write data byte.
            if (act_q == 2'h0) o_sda_oe_n <= 1'b0;
            if (act_q == 2'h0) o_scl_oe_n <= 1'b0;
            if (act_q == 2'h1) o_scl_oe_n <= 1'b1;
            if (act_q == 2'h2) o_sda_oe_n <= 1'b1;
          end
          K_BITS: begin
            if (act_q == 2'h0) o_sda_oe_n <= act_bit;
            if (act_q == 2'h1) o_scl_oe_n <= 1'b1;
            if (act_q == 2'h3) o_scl_oe_n <= 1'b0;
          end
          default: ;
        endcase
      end else begin
        unique case (act_kind)
          K_BITS: begin
            if (act_q == 2'h0) o_mosi <= act_bit;
            if (act_q == 2'h1) o_sck  <= 1'b1;
            if (act_q == 2'h3) o_sck  <= 1'b0;
          end
          K_SEL: begin
            if (act_q == 2'h0) o_sck <= 1'b0;
            if (act_q == 2'h1) begin
              o_spi_cs_n <= (proto == PROTO_MW);
              o_mw_cs    <= (proto == PROTO_MW);
              o_wp_n     <= 1'b1;
            end
          end
          K_DESEL: begin
            // Clock is held low two quarters before and after the select edge.
            if (act_q == 2'h0) o_sck  <= 1'b0;
            if (act_q == 2'h0) o_wp_n <= (proto != PROTO_SPI);
            if (act_q == 2'h2) begin
              o_spi_cs_n <= 1'b1;
              o_mw_cs    <= 1'b0;
            end
            if (act_q == 2'h3) o_wp_n <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Recovery sequencer
  // ----------------------------------------------------------------
  always_comb begin
    if (proto == PROTO_I2C) begin
      poll_ready = !rx_sh[0];
    end else if (proto == PROTO_SPI) begin
      poll_ready = !rx_sh[WRITE_IN_PROGRESS_BIT];
    end else begin
      poll_ready = rx_sh[0];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state    <= S_IDLE;
      step     <= 4'h0;
      waiting  <= 1'b0;
      poll_cnt <= '0;
      proto    <= PROTO_I2C;
      boot     <= 1'b1;
    end else begin
      if (go) waiting <= 1'b1;
      unique case (state)
        S_IDLE, S_DONE, S_FAIL: begin
          if (boot || i_start) begin
            boot     <= 1'b0;
            proto    <= i_protocol;
            state    <= S_DESEL;
            step     <= 4'h0;
            poll_cnt <= '0;
          end
        end
        S_DESEL, S_POLL, S_DISABLE: begin
          if (slot_done) begin
            waiting <= 1'b0;
            if (step == last_step) begin
              step <= 4'h0;
              if (state == S_DESEL) begin
                state <= S_POLL;
              end else if (state == S_POLL) begin
                state <= S_CHECK;
              end else begin
                state <= S_DONE;
              end
            end else begin
              step <= step + 4'h1;
            end
          end
        end
        S_CHECK: begin
          if (!poll_ready) begin
            // A memory that never finishes would otherwise lock the system.
            if (poll_cnt == P_LAST) begin
              state <= S_FAIL;
            end else begin
              poll_cnt <= poll_cnt + PW'(1);
              state    <= S_POLL;
            end
          end else if (proto == PROTO_I2C) begin
            state <= S_DONE;
          end else if ((proto == PROTO_MW) || rx_sh[WRITE_ENABLE_LATCH_FLAG]) begin
            state <= S_DISABLE;
          end else begin
            state <= S_DONE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // User status
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy   <= 1'b1;
      o_ready  <= 1'b0;
      o_failed <= 1'b0;
    end else begin
      o_busy   <= (state != S_DONE) && (state != S_FAIL);
      o_ready  <= (state == S_DONE);
      o_failed <= (state == S_FAIL);
    end
  end

  // The pointer is undefined after a cut-off command; setting wins over the clear.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_need_random_read <= 1'b0;
    end else if ((state == S_CHECK) && poll_ready && (proto == PROTO_I2C)) begin
      o_need_random_read <= 1'b1;
    end else if (i_pointer_loaded || (state == S_DESEL)) begin
      o_need_random_read <= 1'b0;
    end
  end

endmodule // srr_recovery_host

// ==== test/srr_recovery_host_assertions.sv ====
`timescale 1ns/100ps
module srr_checker
  import srr_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_start,
  input  wire logic i_pointer_loaded,
  input  wire logic o_spi_cs_n,
  input  wire logic o_mw_cs,
  input  wire logic o_sck,
  input  wire logic o_wp_n,
  input  wire logic o_busy,
  input  wire logic o_ready,
  input  wire logic o_failed,
  input  wire logic o_need_random_read
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ----
  // Pin order at select and deselect
  // ----
  property p_wp_desel; $rose(o_spi_cs_n) |-> !o_wp_n; endproperty
  a_wp_desel: assert property (p_wp_desel) else $error("deselect with protect high");
  property p_wp_sck; !o_wp_n |-> !o_sck; endproperty
  a_wp_sck: assert property (p_wp_sck) else $error("clock high while protect low");
  property p_spi_cs_sck; $changed(o_spi_cs_n) |-> !o_sck; endproperty
  a_spi_cs_sck: assert property (p_spi_cs_sck) else $error("spi select moved with clock high");
  property p_mw_cs_sck; $changed(o_mw_cs) |-> !o_sck; endproperty
  a_mw_cs_sck: assert property (p_mw_cs_sck) else $error("mw select moved with clock high");
  property p_sck_sel; $rose(o_sck) |-> (!o_spi_cs_n || o_mw_cs); endproperty
  a_sck_sel: assert property (p_sck_sel) else $error("clock edge with no part selected");

  // ----
  // Sequencer status
  // ----
  property p_start_busy; (i_start && (o_ready || o_failed)) |-> ##2 o_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("restart not taken");
  property p_ready_stands;
    o_ready && !i_start && !$past(i_start) && !$past(i_start, 2) |=> o_ready;
  endproperty
  a_ready_stands: assert property (p_ready_stands) else $error("ready dropped");
  property p_busy_ends; $fell(o_busy) |-> ##[0:2] (o_ready || o_failed); endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("run ended with no verdict");
  property p_ready_fail; o_ready |-> !o_failed; endproperty
  a_ready_fail: assert property (p_ready_fail) else $error("ready and failed together");
  property p_need_clear;
    o_need_random_read && i_pointer_loaded && !o_busy |=> !o_need_random_read;
  endproperty
  a_need_clear: assert property (p_need_clear) else $error("pointer flag not cleared");

  c_ready: cover property ($rose(o_ready));
  c_failed: cover property ($rose(o_failed));
  c_need: cover property ($rose(o_need_random_read));
  c_wp: cover property ($fell(o_wp_n));
endmodule // srr_checker

bind srr_recovery_host srr_checker u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(i_start), .i_pointer_loaded(i_pointer_loaded),
  .o_spi_cs_n(o_spi_cs_n), .o_mw_cs(o_mw_cs), .o_sck(o_sck), .o_wp_n(o_wp_n), .o_busy(o_busy),
  .o_ready(o_ready), .o_failed(o_failed), .o_need_random_read(o_need_random_read)
);

// ==== test/srr_eeprom_model.sv ====
`timescale 1ns/100ps
module srr_eeprom_model (
  input  wire logic       i_load,
  input  wire logic [7:0] i_busy_polls,
  input  wire logic       i_wel,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_mw_cs,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_wp_n,
  output logic            o_sda_low,
  output logic            o_dout,
  output logic [7:0]      o_polls,
  output logic [7:0]      o_disables,
  output logic            o_wel,
  output logic            o_err
);
  logic [7:0]  busy_left;
  logic [4:0]  bcnt;
  logic [3:0]  nbyte;
  logic [5:0]  cnt;
  logic [15:0] sh;
  logic [7:0]  cmd;
  logic [7:0]  stat;
  logic        drv;
  logic        dbit;

  always @(posedge i_load) begin
    busy_left = i_busy_polls;
    o_wel = i_wel;
    o_polls = 8'h00;
    o_disables = 8'h00;
    o_err = 1'b0;
    o_sda_low = 1'b0;
    drv = 1'b0;
    dbit = 1'b0;
    bcnt = 5'h1f;
    nbyte = 4'h0;
  end

  // ----
  // Two-wire side
  // ----
  // A Start is decoded in every state and restarts the protocol.
  always @(negedge i_sda) if (i_scl) begin
    bcnt = 5'h00;
    nbyte = 4'h0;
    o_sda_low = 1'b0;
  end
  // A Stop parks the part in standby; a cut-off command stays paused meanwhile.
  // A Stop right after a data byte of a write launches programming.
  always @(posedge i_sda) if (i_scl) begin
    if (nbyte > 4'h2 && bcnt == 5'h01) busy_left = 8'h02;
    bcnt = 5'h1f;
  end
  always @(posedge i_scl) if (bcnt != 5'h1f) bcnt = bcnt + 5'h01;
  // Acknowledge only once the self-timed write has finished.
  always @(negedge i_scl) begin
    if (bcnt == 5'h08 && nbyte == 4'h0) begin
      o_polls = o_polls + 8'h01;
      o_sda_low = (busy_left == 8'h00);
      if (busy_left != 8'h00) busy_left = busy_left - 8'h01;
    end else begin
      o_sda_low = 1'b0;
    end
    // Each byte ends with its acknowledge clock; the count restarts for the next one.
    if (bcnt == 5'h09) begin
      nbyte = nbyte + 4'h1;
      bcnt = 5'h00;
    end
  end

  // ----
  // Four-wire and three-wire side
  // ----
  always @(negedge i_spi_cs_n) begin
    cnt = 6'h00;
    cmd = 8'h00;
    drv = 1'b0;
  end
  always @(posedge i_mw_cs) cnt = 6'h00;
  always @(posedge i_sck) if (!i_spi_cs_n || i_mw_cs) begin
    sh = {sh[14:0], i_mosi};
    cnt = cnt + 6'h01;
    if (cnt == 6'h08) cmd = sh[7:0];
    if (cnt == 6'h08) stat = {6'h00, o_wel, busy_left != 8'h00};
  end
  always @(negedge i_sck) if (!i_spi_cs_n && cmd == 8'h05 && cnt >= 6'h08 && cnt < 6'h10) begin
    drv = 1'b1;
    dbit = stat[15 - cnt];
  end
  // Deselect returns to standby and releases the output.
  always @(posedge i_spi_cs_n) begin
    drv = 1'b0;
    if (cmd == 8'h05 && cnt == 6'h10) begin
      o_polls = o_polls + 8'h01;
      if (busy_left != 8'h00) busy_left = busy_left - 8'h01;
    end
    if (cmd == 8'h04 && cnt == 6'h08) begin
      o_err = o_err | (busy_left != 8'h00);
      o_disables = o_disables + 8'h01;
      o_wel = 1'b0;
    end
    // A write cut at a byte boundary programs unless protect was low.
    if (cmd == 8'h02 && cnt >= 6'h18 && cnt[2:0] == 3'h0 && i_wp_n) busy_left = 8'h02;
  end
  always @(negedge i_mw_cs) begin
    if (cnt == 6'h00) begin
      o_polls = o_polls + 8'h01;
      if (busy_left != 8'h00) busy_left = busy_left - 8'h01;
    end
    if (cnt == 6'h09 && sh[8:4] == 5'b10011) begin
      o_err = o_err | (busy_left != 8'h00);
      o_disables = o_disables + 8'h01;
    end
  end
  // A released output shows the inverse of its last bit, never a held value.
  assign o_dout = i_mw_cs ? (busy_left == 8'h00) : (drv ? dbit : ~dbit);
endmodule // srr_eeprom_model

// ==== test/srr_recovery_host_tb_top.sv ====
`timescale 1ns/100ps
module srr_recovery_host_tb_top;
  import srr_pkg::*;
  localparam int LIMIT = 100000;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_start = 1'b0, i_pointer_loaded = 1'b0;
  srr_proto_type i_protocol = PROTO_I2C;
  logic o_scl, o_scl_oe_n, o_sda, o_sda_oe_n, o_spi_cs_n, o_mw_cs, o_sck, o_mosi, o_wp_n;
  logic o_busy, o_ready, o_failed, o_need_random_read, scl_w, sda_w;
  logic m_load = 1'b0, m_wel = 1'b0, m_sda_low, m_dout, m_wel_q, m_err;
  logic [7:0] m_busy = 8'h00, m_polls, m_dis;
  int n_mismatch = 0, total_checks = 0, cycles = 0, n_start = 0, n_stop = 0, first_starts = 0;

  // Open-drain lines with pull-ups.
  assign scl_w = o_scl_oe_n | o_scl;
  assign sda_w = (o_sda_oe_n | o_sda) & ~m_sda_low;

  srr_recovery_host #(.POLL_MAX(4)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(i_start), .i_protocol(i_protocol),
    .i_pointer_loaded(i_pointer_loaded), .i_sda(sda_w), .i_serial_in(m_dout), .o_scl(o_scl),
    .o_scl_oe_n(o_scl_oe_n), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_spi_cs_n(o_spi_cs_n),
    .o_mw_cs(o_mw_cs), .o_sck(o_sck), .o_mosi(o_mosi), .o_wp_n(o_wp_n), .o_busy(o_busy),
    .o_ready(o_ready), .o_failed(o_failed), .o_need_random_read(o_need_random_read));

  srr_eeprom_model mem (
    .i_load(m_load), .i_busy_polls(m_busy), .i_wel(m_wel), .i_scl(scl_w), .i_sda(sda_w),
    .i_spi_cs_n(o_spi_cs_n), .i_mw_cs(o_mw_cs), .i_sck(o_sck), .i_mosi(o_mosi), .i_wp_n(o_wp_n),
    .o_sda_low(m_sda_low), .o_dout(m_dout), .o_polls(m_polls), .o_disables(m_dis),
    .o_wel(m_wel_q), .o_err(m_err));

  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end
  always @(negedge sda_w) if (scl_w === 1'b1) n_start++;
  always @(posedge sda_w) if (scl_w === 1'b1) begin
    n_stop++;
    if (n_stop == 1) first_starts = n_start;
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic prep(input srr_proto_type p, input logic [7:0] busy, input logic write_enable_latch_flag);
    i_protocol = p;
    m_busy = busy;
    m_wel = write_enable_latch_flag;
    m_load = 1'b1;
    #1 m_load = 1'b0;
    n_start = 0;
    n_stop = 0;
  endtask
  task automatic wait_done;
    int t = 0;
    while (o_ready !== 1'b1 && o_failed !== 1'b1 && t < 60000) begin
      @(posedge i_clk);
      t++;
    end
    #1 chk(8'(t < 60000), 8'h01, "run finished");
  endtask
  task automatic kick_wait;
    @(posedge i_clk) #1 i_start = 1'b1;
    @(posedge i_clk) #1 i_start = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk(8'(o_busy), 8'h01, "busy after start");
    wait_done();
  endtask

  // ----
  // Scenarios
  // ----
  task automatic test_i2c;
    wait_done();
    chk(8'(o_ready), 8'h01, "i2c ready");
    chk(8'(first_starts), 8'h09, "starts before first stop");
    chk(8'(n_stop), 8'h03, "stop count");
    chk(m_polls, 8'h02, "i2c polls");
    chk(8'(o_need_random_read), 8'h01, "pointer flag");
    @(posedge i_clk) #1 i_pointer_loaded = 1'b1;
    @(posedge i_clk) #1 i_pointer_loaded = 1'b0;
    chk(8'(o_need_random_read), 8'h00, "pointer flag cleared");
    $display("test_i2c done");
  endtask
  task automatic test_spi(input logic [7:0] busy, input logic write_enable_latch_flag, input logic [7:0] n_dis);
    prep(PROTO_SPI, busy, write_enable_latch_flag);
    kick_wait();
    chk(8'(o_ready), 8'h01, "spi ready");
    chk(m_polls, busy + 8'h01, "spi polls");
    chk(m_dis, n_dis, "spi disables");
    chk(8'(m_wel_q), 8'h00, "latch flag");
    chk(8'(m_err), 8'h00, "access while busy");
    chk(8'(o_need_random_read), 8'h00, "no pointer flag");
    $display("test_spi done");
  endtask
  task automatic test_mw(input logic [7:0] busy, input logic [7:0] polls, input logic ok);
    prep(PROTO_MW, busy, 1'b0);
    kick_wait();
    chk(8'(o_ready), 8'(ok), "mw ready");
    chk(8'(o_failed), 8'(!ok), "mw failed");
    chk(m_polls, polls, "mw polls");
    chk(m_dis, 8'(ok), "mw disables");
    chk(8'(m_err), 8'h00, "access while busy");
    $display("test_mw done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The partner is loaded once reset has settled every pin, so no time-zero race.
  initial begin
    repeat (15) @(posedge i_clk);
    #1 prep(PROTO_I2C, 8'h01, 1'b0);
    @(posedge i_clk) #1 i_arst_n = 1'b1;
    test_i2c();
    test_spi(8'h01, 1'b1, 8'h01);
    test_spi(8'h00, 1'b0, 8'h00);
    test_mw(8'h01, 8'h02, 1'b1);
    test_mw(8'h64, 8'h04, 1'b0);
    conclude();
  end
endmodule // srr_recovery_host_tb_top
